// ---- hdl/tpl_defs.vh ----
// Constants for the trigger position list block: register offsets, fields and codes.
// Included by the block's single design file; holds definitions only.
`ifndef TPL_DEFS_VH
`define TPL_DEFS_VH

// Register word offsets, taken from byte address bits 4..2.
`define TPL_OFS_CTRL 3'h0
`define TPL_OFS_INDEX 3'h1
`define TPL_OFS_POS 3'h2
`define TPL_OFS_CMD 3'h3
`define TPL_OFS_STATUS 3'h4
`define TPL_OFS_RDATA 3'h5
`define TPL_OFS_AXPOS 3'h6

// Control register fields.
`define TPL_CTRL_EN 0
`define TPL_CTRL_POL 1
`define TPL_CTRL_RANGE 2
`define TPL_CTRL_UNIT_LO 4
`define TPL_CTRL_UNIT_HI 6

// Command register fields and opcodes.
`define TPL_CMD_OP_LO 0
`define TPL_CMD_OP_HI 1
`define TPL_CMD_AXG 4
`define TPL_CMD_AX_LO 8
`define TPL_CMD_AX_HI 9
`define TPL_OP_WRITE 2'h1
`define TPL_OP_READ 2'h2
`define TPL_OP_CLEAR 2'h3

// Special list indices.
`define TPL_IDX_LAST 16'hffff
`define TPL_IDX_ZERO 16'h0000

// Trigger modes chosen by the list direction.
`define TPL_MODE_UP 8'h14
`define TPL_MODE_DOWN 8'h15

// Status register field positions.
`define TPL_ST_ERR 16
`define TPL_ST_DIR 17
`define TPL_ST_ARMED 18
`define TPL_ST_AX_LO 20
`define TPL_ST_AX_HI 21
`define TPL_ST_MODE_LO 24
`define TPL_ST_MODE_HI 31

// Reset values.
`define TPL_CTRL_RST 32'h00000000
`define TPL_ZERO32 32'h00000000

`endif

// ---- hdl/tpl_trigger_list.v ----
// Trigger position list: holds monotonic positions for one axis and pulses a trigger as the axis passes each.
// Assumes Avalon-MM registers on SYS_CLK and axis positions from logic on the same clock, in internal units.
// Operation
// RULE1: Store up to 10000 positions in selected unit.
// RULE2: List write picks mode 20 or 21 itself.
// RULE3: Entries belong only to their written axis.
// RULE4: No axis uses stored; first/clear axis persists.
// RULE5: Axis change with entries present: ignore, error.
// RULE6: Entries monotonic; direction from first two entries.
// RULE7: Single entry: direction from current axis position.
// RULE8: List persists; re-arm when axis behind first.
// RULE9: Host reloads list per direction before moves.
// RULE10: Index 0 empties list; axis given selects it.
// RULE11: Index -1 appends and increments the count.
// RULE12: Axis with -1 only accepted on empty list.
// RULE13: Index n replaces, or appends when count n-1.
// RULE14: Read index -1 returns the last entry.
// RULE15: Read returns entry in selected unit.
// RULE16: Host sets mode before polarity for immediacy.
// RULE17: Scan re-enables itself before first position.
// RULE18: Range load clears list; list write clears range.
// RULE19: Crossing current entry pulses trigger, advances pointer.
`include "tpl_defs.vh"
`timescale 1ns/10ps

module tpl_trigger_list #(
  parameter DEPTH = 10000,
  parameter CW = 14
) (
  // Clock and reset.
  input wire SYS_CLK,
  input wire SYS_RST,
  // Avalon-MM slave.
  input wire [4:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  // Axis positions x, y, z, a.
  input wire [31:0] AXIS_POS_X,
  input wire [31:0] AXIS_POS_Y,
  input wire [31:0] AXIS_POS_Z,
  input wire [31:0] AXIS_POS_A,
  // Trigger output and current mode.
  output reg TRIG_OUT,
  output reg [7:0] TRIG_MODE
);

  // List storage, fill count and scan state.
  reg [31:0] mem [0:DEPTH-1];
  reg [CW-1:0] count_reg;
  reg [CW-1:0] ptr_reg;
  reg [1:0] axis_reg;
  reg armed_reg;
  reg dir_single_reg;
  reg err_reg;

  // Bus handshake, enable edge and trigger pulse state.
  reg ack_reg;
  reg en_d_reg;
  reg pulse_reg;

  // Software-visible registers.
  reg [31:0] ctrl_reg;
  reg [15:0] index_reg;
  reg [31:0] pos_reg;
  reg [31:0] rdata_reg;

  // Combinational helpers.
  reg [31:0] cur_pos;
  reg [31:0] sel_pos;
  reg [31:0] status_word;
  reg [31:0] wmask;

  // Bus decode and control fields.
  wire [2:0] word = AVS_ADDRESS[4:2];
  wire take = AVS_WRITE & ack_reg;
  wire en = ctrl_reg[`TPL_CTRL_EN];
  wire [2:0] unit = ctrl_reg[`TPL_CTRL_UNIT_HI:`TPL_CTRL_UNIT_LO];
  // List entries the scan compares against.
  wire [31:0] first_e = mem[0];
  wire [31:0] second_e = mem[1];
  wire [31:0] cur_e = mem[ptr_reg];
  wire dir_up;
  // Count arithmetic; the default depth fits the count width.
  localparam [CW-1:0] DEPTH_C = DEPTH;
  wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};
  wire [CW-1:0] depth_c = DEPTH_C;
  wire [CW-1:0] nidx = index_reg[CW-1:0];
  // Positions are stored in internal units, shifted up from the selected unit.
  wire [31:0] pos_int = pos_reg <<< unit;

  // Command word fields, decoded once for the list process.
  wire [1:0] cmd_op = AVS_WRITEDATA[`TPL_CMD_OP_HI:`TPL_CMD_OP_LO];
  wire cmd_axg = AVS_WRITEDATA[`TPL_CMD_AXG];
  wire [1:0] cmd_ax = AVS_WRITEDATA[`TPL_CMD_AX_HI:`TPL_CMD_AX_LO];
  wire cmd_take = take && (word == `TPL_OFS_CMD);
  // A range load is a control write that sets the range bit in the low byte.
  wire range_take = take && (word == `TPL_OFS_CTRL) && AVS_BYTEENABLE[0] && AVS_WRITEDATA[`TPL_CTRL_RANGE];

  // Index classes; bits above the count width must be clear, or a large index would alias a small one.
  wire idx_zero = (index_reg == `TPL_IDX_ZERO);
  wire idx_last = (index_reg == `TPL_IDX_LAST);
  wire idx_fits = (index_reg[15:CW] == {(16-CW){1'b0}});
  // Positive index n addresses slot n-1.
  wire [CW-1:0] n_slot = nidx - one;
  wire list_empty = (count_reg == {CW{1'b0}});
  wire list_full = (count_reg == depth_c);

  // Byte enables turn into a bit mask for register writes.
  always @* begin
    wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  end

  // Only the stored trigger axis feeds the comparison, so entries never apply to another axis.
  always @* begin
    case (axis_reg)
      2'h0: cur_pos = AXIS_POS_X; // RULE3
      2'h1: cur_pos = AXIS_POS_Y;
      2'h2: cur_pos = AXIS_POS_Z;
      default: cur_pos = AXIS_POS_A;
    endcase
  end

  // Position of the axis a command names, so a first entry is judged against its own axis.
  // Without an axis in the command the stored trigger axis is used.
  always @* begin
    sel_pos = cur_pos;
    if (cmd_axg) begin
      case (cmd_ax)
        2'h0: sel_pos = AXIS_POS_X;
        2'h1: sel_pos = AXIS_POS_Y;
        2'h2: sel_pos = AXIS_POS_Z;
        default: sel_pos = AXIS_POS_A;
      endcase
    end
  end

  // Direction from the first two entries, or from the single-entry decision.
  assign dir_up = (count_reg > one) ? ($signed(second_e) > $signed(first_e)) : dir_single_reg; // RULE6

  // Scan comparisons: strictly behind the first entry re-arms, reaching the current entry fires.
  wire behind_first = dir_up ? ($signed(cur_pos) < $signed(first_e)) : ($signed(cur_pos) > $signed(first_e));
  wire at_entry = dir_up ? ($signed(cur_pos) >= $signed(cur_e)) : ($signed(cur_pos) <= $signed(cur_e));

  // Status word: count, error, direction, armed flag, axis and mode.
  always @* begin
    status_word = `TPL_ZERO32;
    status_word[CW-1:0] = count_reg;
    status_word[`TPL_ST_ERR] = err_reg;
    status_word[`TPL_ST_DIR] = dir_up;
    status_word[`TPL_ST_ARMED] = armed_reg;
    status_word[`TPL_ST_AX_HI:`TPL_ST_AX_LO] = axis_reg;
    status_word[`TPL_ST_MODE_HI:`TPL_ST_MODE_LO] = TRIG_MODE;
  end

  // Each access gets one wait state; a write acts on the cycle waitrequest is low, a read samples in the wait cycle.
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;

  // Wait state tracking.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
    end
  end

  // Read data is captured in the wait cycle and stands through the answer cycle.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      AVS_READDATA <= `TPL_ZERO32;
    end else if (AVS_READ & ~ack_reg) begin
      case (word)
        `TPL_OFS_CTRL: AVS_READDATA <= ctrl_reg;
        `TPL_OFS_INDEX: AVS_READDATA <= {16'h0000, index_reg};
        `TPL_OFS_POS: AVS_READDATA <= pos_reg;
        `TPL_OFS_STATUS: AVS_READDATA <= status_word;
        `TPL_OFS_RDATA: AVS_READDATA <= rdata_reg;
        // The axis position is shown in the selected unit.
        `TPL_OFS_AXPOS: AVS_READDATA <= $signed(cur_pos) >>> unit;
        default: AVS_READDATA <= `TPL_ZERO32;
      endcase
    end
  end

  // Plain register writes; writing the range bit stands for a range load.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_reg <= `TPL_CTRL_RST;
      index_reg <= 16'h0000;
      pos_reg <= `TPL_ZERO32;
    end else if (take) begin
      case (word)
        `TPL_OFS_CTRL: ctrl_reg <= (ctrl_reg & ~wmask) | (AVS_WRITEDATA & wmask);
        `TPL_OFS_INDEX: index_reg <= (index_reg & ~wmask[15:0]) | (AVS_WRITEDATA[15:0] & wmask[15:0]);
        `TPL_OFS_POS: pos_reg <= (pos_reg & ~wmask) | (AVS_WRITEDATA & wmask);
        `TPL_OFS_CMD: begin
          // The command word is not stored; any list write cancels a pending range setting.
          if (AVS_WRITEDATA[`TPL_CMD_OP_HI:`TPL_CMD_OP_LO] == `TPL_OP_WRITE) begin
            ctrl_reg[`TPL_CTRL_RANGE] <= 1'b0; // RULE18
          end
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // List commands, scanning and trigger generation share the list state.
  always @(posedge SYS_CLK) begin : list_proc
    if (SYS_RST) begin
      count_reg <= {CW{1'b0}};
      ptr_reg <= {CW{1'b0}};
      axis_reg <= 2'h0;
      armed_reg <= 1'b0;
      dir_single_reg <= 1'b1;
      err_reg <= 1'b0;
      en_d_reg <= 1'b0;
      pulse_reg <= 1'b0;
      rdata_reg <= `TPL_ZERO32;
    end else begin
      en_d_reg <= en;
      pulse_reg <= 1'b0;
      // A range load empties the list.
      if (range_take) begin
        count_reg <= {CW{1'b0}}; // RULE18
        armed_reg <= 1'b0;
      end else if (cmd_take) begin
        // Every command starts with a clean error flag; a refused one sets it again.
        err_reg <= 1'b0;
        case (cmd_op)
          `TPL_OP_CLEAR: begin
            count_reg <= {CW{1'b0}}; // RULE10
            ptr_reg <= {CW{1'b0}};
            armed_reg <= 1'b0;
            if (cmd_axg) begin
              axis_reg <= cmd_ax; // RULE4
            end
          end
          `TPL_OP_WRITE: begin
            if (idx_zero) begin
              // Index zero on a write empties the list, like a clear.
              count_reg <= {CW{1'b0}}; // RULE10
              ptr_reg <= {CW{1'b0}};
              armed_reg <= 1'b0;
              if (cmd_axg) begin
                axis_reg <= cmd_ax;
              end
            end else if (cmd_axg && !list_empty && cmd_ax != axis_reg) begin
              // The axis is locked while entries exist; they would be meaningless on another axis.
              err_reg <= 1'b1; // RULE5
            end else if (idx_last) begin
              if (list_full) begin
                err_reg <= 1'b1; // RULE1
              end else if (cmd_axg && !list_empty) begin
                err_reg <= 1'b1; // RULE12
              end else begin
                mem[count_reg] <= pos_int; // RULE11
                count_reg <= count_reg + one;
                if (cmd_axg) begin
                  axis_reg <= cmd_ax; // RULE12
                end
                // The first entry is judged against the axis it is written for.
                if (list_empty) begin
                  dir_single_reg <= $signed(pos_int) > $signed(sel_pos); // RULE7
                  ptr_reg <= {CW{1'b0}};
                  armed_reg <= 1'b1;
                end
              end
            end else if (!idx_fits || nidx > count_reg + one || nidx > depth_c) begin
              // Negative indices other than the last, and gaps in the list, are refused.
              err_reg <= 1'b1;
            end else begin
              mem[n_slot] <= pos_int; // RULE13
              // An index one past the end appends instead of replacing.
              if (nidx == count_reg + one) begin
                count_reg <= count_reg + one;
              end
              if (list_empty) begin
                if (cmd_axg) begin
                  axis_reg <= cmd_ax; // RULE4
                end
                dir_single_reg <= $signed(pos_int) > $signed(sel_pos); // RULE7
                ptr_reg <= {CW{1'b0}};
                armed_reg <= 1'b1;
              end
            end
          end
          `TPL_OP_READ: begin
            // Reads convert back to the selected unit with an arithmetic shift.
            if (idx_last && !list_empty) begin
              rdata_reg <= $signed(mem[count_reg - one]) >>> unit; // RULE14
            end else if (idx_fits && nidx != {CW{1'b0}} && nidx <= count_reg) begin
              rdata_reg <= $signed(mem[n_slot]) >>> unit; // RULE15
            end else begin
              err_reg <= 1'b1;
            end
          end
          default: err_reg <= 1'b0;
        endcase
      end else if (!list_empty) begin
        // Enabling with one entry decides direction against the present position.
        if (en && !en_d_reg && count_reg == one) begin
          dir_single_reg <= $signed(first_e) > $signed(cur_pos); // RULE7
        end
        // Axis behind the first entry re-arms the scan without touching the enable.
        if (behind_first) begin
          ptr_reg <= {CW{1'b0}}; // RULE8
          armed_reg <= 1'b1; // RULE17
        end else if (en && armed_reg && at_entry) begin
          // One pulse per entry; the last entry disarms until the axis comes back.
          pulse_reg <= 1'b1; // RULE19
          ptr_reg <= ptr_reg + one;
          if (ptr_reg + one == count_reg) begin
            armed_reg <= 1'b0;
          end
        end
      end
    end
  end

  // Polarity applies at the output flop, so the idle level equals the polarity bit.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TRIG_OUT <= 1'b0;
    end else begin
      TRIG_OUT <= pulse_reg ^ ctrl_reg[`TPL_CTRL_POL];
    end
  end

  // Mode follows the list direction without a separate mode setting.
  always @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TRIG_MODE <= `TPL_MODE_UP;
    end else begin
      TRIG_MODE <= dir_up ? `TPL_MODE_UP : `TPL_MODE_DOWN; // RULE2
    end
  end

endmodule

// ---- sim/tpl_trigger_list_props.sv ----
// Checker for the trigger position list: bus handshake, trigger mode and trigger output.
// Assumes it is bound to the top design module and sees only that module's ports.
`timescale 1ns/10ps
module tpl_props (
  // Clock and reset.
  input wire SYS_CLK,
  input wire SYS_RST,
  // Register bus.
  input wire [4:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  // Trigger side.
  input wire TRIG_OUT,
  input wire [7:0] TRIG_MODE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  // A new request first waits, then completes one cycle later.
  sequence s_start;
    $rose(AVS_READ || AVS_WRITE) ##0 AVS_WAITREQUEST;
  endsequence
  sequence s_done;
    !AVS_WAITREQUEST;
  endsequence
  AST_ONE_WAIT: assert property (s_start |=> s_done)
    else $error("wait state count wrong");
  AST_IDLE_NOWAIT: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
    else $error("wait asserted without request");
  AST_RDATA_HOLD: assert property ($changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
    else $error("read data moved outside a read");
  AST_UNMAPPED: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[4:2] == 3'h7 |-> AVS_READDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_MODE_SET: assert property (TRIG_MODE == 8'h14 || TRIG_MODE == 8'h15)
    else $error("illegal trigger mode");
  AST_MODE_CAUSE: assert property ($changed(TRIG_MODE) |-> $past(AVS_WRITE && !AVS_WAITREQUEST) || $past(AVS_WRITE && !AVS_WAITREQUEST, 2))
    else $error("mode changed without a write");
  AST_RESET_STATE: assert property ($fell(SYS_RST) |-> TRIG_MODE == 8'h14 && AVS_READDATA == 32'h0 && !TRIG_OUT)
    else $error("reset state wrong");
  AST_PULSE_ONE: assert property ($rose(TRIG_OUT) && !$past(AVS_WRITE && !AVS_WAITREQUEST, 2) |=> $fell(TRIG_OUT))
    else $error("trigger pulse not one cycle");
endmodule

bind tpl_trigger_list tpl_props u_props (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .TRIG_OUT(TRIG_OUT), .TRIG_MODE(TRIG_MODE));

// ---- sim/tpl_axis_src.sv ----
// Moving axis model: steps one internal unit per clock toward the commanded goal.
// Assumes the bench changes the goal only after the previous move has ended.
`timescale 1ns/10ps
module tpl_axis_src (
  // Clock and reset.
  input wire clk,
  input wire rst,
  // Commanded and present position.
  input wire signed [31:0] goal,
  output reg signed [31:0] pos
);
  // Reset parks the axis at the goal, so the first move starts before the list.
  always @(posedge clk) begin
    if (rst)
      pos <= goal;
    else if (pos < goal)
      pos <= pos + 32'sd1;
    else if (pos > goal)
      pos <= pos - 32'sd1;
  end
endmodule

// ---- sim/tpl_trigger_list_test.sv ----
// Self-checking bench for the trigger position list with two moving axes.
// Assumes the checker is bound to the design and the axis model moves one unit per clock.
`timescale 1ns/10ps
module tpl_trigger_list_test;
  reg sys_clk, sys_rst, rd, wr, trig_d;
  reg [4:0] adr;
  reg [31:0] wdat, got;
  reg signed [31:0] gx, gy;
  wire [31:0] rdat, px, py;
  wire wreq, trig;
  wire [7:0] mode;
  integer err_count, compares, pulses;
  tpl_trigger_list u_dut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .AXIS_POS_X(px), .AXIS_POS_Y(py), .AXIS_POS_Z(32'h0),
    .AXIS_POS_A(32'h0), .TRIG_OUT(trig), .TRIG_MODE(mode));
  tpl_axis_src u_ax (.clk(sys_clk), .rst(sys_rst), .goal(gx), .pos(px));
  tpl_axis_src u_ay (.clk(sys_clk), .rst(sys_rst), .goal(gy), .pos(py));
  // Clock generator.
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Counts rising trigger edges, polarity stays low until the last step of t_misc sets it.
  always @(posedge sys_clk) begin
    trig_d <= trig;
    if (trig === 1'b1 && trig_d === 1'b0) pulses = pulses + 1;
  end
  task chk(input [31:0] g, input [31:0] e); begin
    compares = compares + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  end endtask
  task bus(input w, input [4:0] a, input [31:0] d); begin
    @(posedge sys_clk);
    adr <= a; wdat <= d; wr <= w; rd <= !w;
    @(posedge sys_clk);
    while (wreq !== 1'b0) @(posedge sys_clk);
    got = rdat;
    rd <= 1'b0; wr <= 1'b0;
  end endtask
  task cmd(input [15:0] i, input [31:0] p, input [31:0] c); begin
    bus(1'b1, 5'h04, {16'h0, i});
    bus(1'b1, 5'h08, p);
    bus(1'b1, 5'h0c, c);
  end endtask
  task st(input [31:0] e); begin
    bus(1'b0, 5'h10, 32'h0);
    chk(got & 32'hfff9ffff, e);
  end endtask
  task go(input [31:0] x, input [31:0] y); begin
    @(posedge sys_clk);
    gx <= x; gy <= y;
    @(posedge sys_clk);
    while (px !== gx || py !== gy) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
  end endtask
  task final_report; begin
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end endtask
  // Upward list on x: edit, read back, scan twice with re-arm between.
  task t_up; begin
    cmd(16'h0, 32'h0, 32'h13);
    cmd(16'hffff, 100, 1); cmd(16'hffff, 110, 1); cmd(16'hffff, 120, 1);
    st(32'h14000003);
    cmd(16'h2, 112, 1); cmd(16'h4, 130, 1);
    cmd(16'hffff, 0, 2); bus(1'b0, 5'h14, 0); chk(got, 130);
    cmd(16'h2, 0, 2); bus(1'b0, 5'h14, 0); chk(got, 112);
    st(32'h14000004);
    bus(1'b1, 5'h00, 32'h1);
    pulses = 0;
    go(140, 50); chk(pulses, 4);
    go(90, 50); go(140, 50); chk(pulses, 8);
    chk({24'h0, mode}, 32'h14);
  end endtask
  // Axis change on a filled list is refused with an error.
  task t_axis; begin
    cmd(16'hffff, 140, 32'h111); st(32'h14010004);
  end endtask
  // Single entry on y below the axis gives a downward scan.
  task t_down; begin
    cmd(16'h0, 0, 32'h113); st(32'h14100000);
    cmd(16'hffff, 40, 1); st(32'h15100001);
    chk({24'h0, mode}, 32'h15);
    pulses = 0;
    go(140, 30); chk(pulses, 1);
    cmd(16'h0, 0, 3); cmd(16'hffff, 5, 32'h211); st(32'h14200001);
  end endtask
  // Unit shift, range load and the unmapped word.
  task t_misc; begin
    bus(1'b1, 5'h00, 32'h10);
    cmd(16'h0, 0, 3); cmd(16'hffff, 7, 1); cmd(16'h1, 0, 2);
    bus(1'b0, 5'h14, 0); chk(got, 7);
    bus(1'b1, 5'h00, 32'h4); bus(1'b0, 5'h10, 0); chk(got & 32'h3fff, 0);
    cmd(16'hffff, 9, 1); bus(1'b0, 5'h00, 0); chk(got & 32'h4, 0);
    bus(1'b0, 5'h1c, 0); chk(got, 0);
    bus(1'b1, 5'h00, 32'h2); repeat (2) @(posedge sys_clk); chk({31'h0, trig}, 1);
  end endtask
  // Watchdog against a hung handshake or move.
  initial begin
    #(5000 * 50);
    err_count = err_count + 1;
    final_report;
  end
  // Main sequence.
  initial begin
    rd = 1'b0; wr = 1'b0; adr = 5'h0; wdat = 32'h0; trig_d = 1'b0;
    gx = 90; gy = 50; err_count = 0; compares = 0; pulses = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    st(32'h14000000);
    t_up;
    t_axis;
    t_down;
    t_misc;
    final_report;
  end
endmodule
